//--- hw/erase_error_defs.svh
`ifndef ERASE_ERROR_DEFS_SVH
`define ERASE_ERROR_DEFS_SVH
// Function
// - bit 31 set when erase flag available
// - bit 30 gives flag polarity, host applies
// - bit 29 set when program/erase share flag
// - bit 28 selects addressed versus direct access
// - bit 27 places local address byte
// - bits 26-24 give flag position
// - bits 23-16 hold local address if addressed
// - bit 23 octal double-rate mode supported
// - bit 22 octal single-rate mode supported
// - bit 21 quad command, quad double-rate data
// - bit 20 all-quad single-rate mode supported
// - bits 19-16 dummy count, host inserts exactly; host sends zero dummies on any addressed access
// - single-lane direct read uses no dummies
// - cleared mode flag not proof of unsupported
// - bits 15-8 read opcode, zero unsupported
// - bits 7-0 write opcode, zero read-only
`define AVAIL_BIT        31
`define POLARITY_BIT     30
`define SHARED_BIT       29
`define ADDRESSED_BIT    28
`define LOCAL_BYTE1_BIT  27
`define POS_HI           26
`define POS_LO           24
`define LADDR_HI         23
`define LADDR_LO         16
`define OCT_DDR_BIT      23
`define OCT_SDR_BIT      22
`define QUAD_DDR_BIT     21
`define QUAD_SDR_BIT     20
`define DUMMY_HI         19
`define DUMMY_LO         16
`define RD_OP_HI         15
`define RD_OP_LO         8
`define WR_OP_HI         7
`define WR_OP_LO         0
`define OFF_CTRL         12'h000
`define OFF_STATUS       12'h004
`define OFF_MASK         12'h008
`define OFF_WORD         12'h00C
`define OFF_RESULT       12'h010
`define OFF_DATA         12'h014
`define RESET_WORD       32'h0000_0000
`endif

//--- hw/erase_error_pkg.sv
package erase_error_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_REQ   = 3'b001,
    ST_WAIT  = 3'b011,
    ST_WREQ  = 3'b010,
    ST_WWAIT = 3'b110
  } host_state_t;
  typedef enum logic [2:0] {
    FORM_SINGLE  = 3'b000,
    FORM_QUAD_S  = 3'b001,
    FORM_QUAD_D  = 3'b010,
    FORM_OCT_S   = 3'b011,
    FORM_OCT_D   = 3'b100
  } lane_form_t;
endpackage : erase_error_pkg

//--- hw/erase_error_if.sv
`timescale 1ns/1ps
interface erase_error_if;
  import erase_error_pkg::*;
  logic              req;
  logic              we;
  logic              addressed;
  logic [31:0]       addr;
  logic [7:0]        opcode;
  logic [3:0]        dummy;
  lane_form_t        form;
  logic [7:0]        wdata;
  logic [31:0]       word;
  logic              ack;
  logic [7:0]        rdata;
  modport device (input req, we, addressed, addr, opcode, dummy, form, wdata,
                  output word, ack, rdata);
  modport host   (output req, we, addressed, addr, opcode, dummy, form, wdata,
                  input word, ack, rdata);
endinterface : erase_error_if

//--- hw/flag_extract.sv
`timescale 1ns/1ps
module flag_extract
  import erase_error_pkg::*;
(
  input  wire logic [7:0] reg_value,
  input  wire logic [2:0] position,
  input  wire logic       inverted,
  output logic            failed
);
  assign failed = reg_value[position] ^ inverted;
endmodule : flag_extract

//--- hw/erase_error_device.sv
`timescale 1ns/1ps
`include "erase_error_defs.svh"
module erase_error_device
  import erase_error_pkg::*;
#(
  parameter logic [31:0] DESC_WORD = 32'h9103_0570
)(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      clk_en,
  erase_error_if.device  link,
  input  wire logic      erase_fail,
  output logic [7:0]     status_reg_value
);
  typedef struct packed {
    logic [7:0] status;
    logic       ack;
  } dev_state_t;
  dev_state_t s_reg;
  dev_state_t s_next;
  logic       flag_val;
  logic [7:0] local_addr;
  // ************
  // descriptor
  // ************
  assign link.word = DESC_WORD;
  assign flag_val = erase_fail ^ DESC_WORD[`POLARITY_BIT];
  assign local_addr = DESC_WORD[`LOCAL_BYTE1_BIT] ? link.addr[15:8] : link.addr[7:0];
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.status[DESC_WORD[`POS_HI:`POS_LO]] = flag_val;
    if (link.req && !s_reg.ack) begin
      if ((link.addressed == DESC_WORD[`ADDRESSED_BIT]) &&
          (!link.addressed || local_addr == DESC_WORD[`LADDR_HI:`LADDR_LO])) begin
        if (link.we && DESC_WORD[`WR_OP_HI:`WR_OP_LO] != 8'h00 &&
            link.opcode == DESC_WORD[`WR_OP_HI:`WR_OP_LO]) begin
          s_next.status = link.wdata;
        end
      end
      s_next.ack = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end
  assign link.ack = s_reg.ack;
  assign link.rdata = s_reg.status;
  assign status_reg_value = s_reg.status;
endmodule : erase_error_device

//--- hw/erase_error_host.sv
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "erase_error_defs.svh"
module erase_error_host
  import erase_error_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  erase_error_if.host      link
);
  typedef struct packed {
    host_state_t state;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [2:0]  form;
    logic [7:0]  wdata;
    logic        failed;
    logic        valid;
    logic [7:0]  rdata;
    logic [31:0] prdata;
  } host_reg_t;
  host_reg_t r_reg;
  host_reg_t r_next;
  logic [31:0] word;
  logic        failed_now;
  logic        wr;
  logic        rd;
  function automatic logic [31:0] build_addr(input logic [31:0] w);
    build_addr = w[`LOCAL_BYTE1_BIT] ? {16'h0000, w[`LADDR_HI:`LADDR_LO], 8'h00} :
                                       {24'h0000_00, w[`LADDR_HI:`LADDR_LO]};
  endfunction : build_addr
  function automatic logic mode_listed(input logic [31:0] w, input lane_form_t f);
    case (f)
      FORM_OCT_D: mode_listed = w[`OCT_DDR_BIT];
      FORM_OCT_S: mode_listed = w[`OCT_SDR_BIT];
      FORM_QUAD_D: mode_listed = w[`QUAD_DDR_BIT];
      FORM_QUAD_S: mode_listed = w[`QUAD_SDR_BIT];
      default: mode_listed = 1'b1;
    endcase
  endfunction : mode_listed
  assign word = link.word;
  flag_extract u_extract (
    .reg_value (link.rdata),
    .position  (word[`POS_HI:`POS_LO]),
    .inverted  (word[`POLARITY_BIT]),
    .failed    (failed_now)
  );
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = r_reg.prdata;
  assign irq = |(r_reg.status & r_reg.mask);
  // ************
  // link drive
  // ************
  assign link.req = (r_reg.state == ST_WAIT) || (r_reg.state == ST_WWAIT);
  assign link.we = (r_reg.state == ST_WWAIT);
  assign link.addressed = word[`ADDRESSED_BIT];
  assign link.addr = word[`ADDRESSED_BIT] ? build_addr(word) : 32'h0000_0000;
  assign link.opcode = link.we ? word[`WR_OP_HI:`WR_OP_LO] : word[`RD_OP_HI:`RD_OP_LO];
  assign link.form = lane_form_t'(r_reg.form);
  assign link.dummy = (link.form == FORM_SINGLE || word[`ADDRESSED_BIT]) ? 4'h0 :
                      word[`DUMMY_HI:`DUMMY_LO];
  assign link.wdata = r_reg.wdata;
  always_comb begin
    r_next = r_reg;
    // read data held through the access phase
    if (rd) begin
      case (paddr)
        `OFF_CTRL:   r_next.prdata = {29'h0, r_reg.form};
        `OFF_STATUS: r_next.prdata = {30'h0, r_reg.status};
        `OFF_MASK:   r_next.prdata = {30'h0, r_reg.mask};
        `OFF_WORD:   r_next.prdata = word;
        `OFF_RESULT: r_next.prdata = {29'h0, mode_listed(word, lane_form_t'(r_reg.form)),
                                      r_reg.valid, r_reg.failed};
        `OFF_DATA:   r_next.prdata = {24'h0, r_reg.rdata};
        default:     r_next.prdata = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == `OFF_STATUS) r_next.status = r_reg.status & ~pwdata[1:0];
    if (wr && paddr == `OFF_MASK) r_next.mask = pwdata[1:0];
    case (r_reg.state)
      ST_IDLE: begin
        if (wr && paddr == `OFF_CTRL) begin
          r_next.form = pwdata[2:0];
          r_next.wdata = pwdata[15:8];
          if (pwdata[4] && word[`WR_OP_HI:`WR_OP_LO] != 8'h00) r_next.state = ST_WREQ;
          else if (pwdata[3]) r_next.state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!word[`AVAIL_BIT] || word[`RD_OP_HI:`RD_OP_LO] == 8'h00) begin
          r_next.valid = 1'b0;
          r_next.status[1] = 1'b1;
          r_next.state = ST_IDLE;
        end else r_next.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (link.ack) begin
          r_next.rdata = link.rdata;
          r_next.failed = failed_now;
          r_next.valid = 1'b1;
          r_next.status[0] = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      ST_WREQ: r_next.state = ST_WWAIT;
      ST_WWAIT: begin
        if (link.ack) begin
          r_next.status[0] = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      default: r_next.state = ST_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end
endmodule : erase_error_host

//--- verification/erase_error_sva.sv
`timescale 1ns/1ps
module erase_error_sva
  import erase_error_pkg::*;
#(
  parameter logic [31:0] DESC_WORD = 32'h9103_0570
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic        addressed,
  input wire logic [31:0] addr,
  input wire logic [7:0]  opcode,
  input wire logic [3:0]  dummy,
  input wire lane_form_t  form,
  input wire logic [31:0] word,
  input wire logic        ack
);
  // ************************************
  // link checks
  // ************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_word_fixed: assert property (word == DESC_WORD)
    else $error("descriptor word differs");
  a_ack_follows_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_held: assert property (req && !ack |=> req)
    else $error("request dropped before ack");
  a_read_opcode: assert property (req && !we |-> opcode == word[15:8])
    else $error("wrong read opcode");
  a_write_opcode: assert property (req && we |-> opcode == word[7:0] && word[7:0] != 8'h00)
    else $error("wrong write opcode");
  a_access_style: assert property (req |-> addressed == word[28])
    else $error("wrong access style");
  a_local_addr: assert property (req && addressed |->
    (word[27] ? addr[15:8] : addr[7:0]) == word[23:16])
    else $error("wrong local address byte");
  a_dummy_count: assert property (req |-> dummy ==
    ((word[28] || form == FORM_SINGLE) ? 4'h0 : word[19:16]))
    else $error("wrong dummy count");
  a_no_req_unsup: assert property (!word[31] || word[15:8] == 8'h00 |-> !req)
    else $error("request while unsupported");
  c_read: cover property (req && !we);
  c_write: cover property (req && we);
  c_ack: cover property (ack);
endmodule : erase_error_sva

//--- verification/erase_error_descriptor_decode_tb.sv
`timescale 1ns/1ps
`include "erase_error_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module erase_error_descriptor_decode_tb;
  import erase_error_pkg::*;
  // ************************************
  // setup
  // ************************************
  localparam logic [31:0] DESC = 32'h9103_0570;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, erase_fail = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, irq;
  logic [7:0]  status_reg_value;
  int          n_mismatch = 0, checked = 0;
  always #25 pclk = ~pclk;
  erase_error_if i_erase_error_if();
  erase_error_host i_erase_error_host(.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(i_erase_error_if));
  erase_error_device #(.DESC_WORD(DESC)) i_erase_error_device(.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .link(i_erase_error_if), .erase_fail(erase_fail),
    .status_reg_value(status_reg_value));
  erase_error_sva #(.DESC_WORD(DESC)) i_erase_error_sva(.pclk(pclk), .presetn(presetn),
    .req(i_erase_error_if.req), .we(i_erase_error_if.we),
    .addressed(i_erase_error_if.addressed), .addr(i_erase_error_if.addr),
    .opcode(i_erase_error_if.opcode), .dummy(i_erase_error_if.dummy),
    .form(i_erase_error_if.form), .word(i_erase_error_if.word), .ack(i_erase_error_if.ack));
  // ************************************
  // tasks
  // ************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic run_op(input logic [31:0] ctrl);
    int i;
    apb(1'b1, `OFF_CTRL, ctrl);
    q = 32'h0000_0000;
    for (i = 0; i < 50 && q[0] !== 1'b1; i++) apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    `CHK(q[0], 1'b1)
  endtask : run_op
  task automatic print_verdict();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // ************************************
  // tests
  // ************************************
  initial begin
    #(50 * 4000);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(irq, 1'b0)
    apb(1'b0, `OFF_WORD, 32'h0000_0000);
    `CHK(q, DESC)
    $display("test descriptor done");
    erase_fail <= 1'b1;
    apb(1'b1, `OFF_MASK, 32'h0000_0001);
    run_op(32'h0000_0008);
    apb(1'b0, `OFF_RESULT, 32'h0000_0000);
    `CHK(q[1:0], 2'b11)
    `CHK(q[2], 1'b1)
    apb(1'b0, `OFF_DATA, 32'h0000_0000);
    `CHK(q[1], 1'b1)
    `CHK(irq, 1'b1)
    apb(1'b1, `OFF_STATUS, 32'h0000_0001);
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    `CHK(q[0], 1'b0)
    `CHK(irq, 1'b0)
    $display("test failed erase done");
    erase_fail <= 1'b0;
    run_op(32'h0000_0009);
    apb(1'b0, `OFF_RESULT, 32'h0000_0000);
    `CHK(q[1:0], 2'b10)
    `CHK(q[2], 1'b0)
    apb(1'b1, `OFF_STATUS, 32'h0000_0001);
    $display("test passed erase done");
    run_op(32'h0000_A510);
    `CHK(irq, 1'b1)
    `CHK(status_reg_value, 8'hA5)
    apb(1'b0, `OFF_DATA, 32'h0000_0000);
    apb(1'b1, `OFF_MASK, 32'h0000_0000);
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    `CHK(irq, 1'b0)
    `CHK(q[0], 1'b1)
    apb(1'b1, `OFF_STATUS, 32'h0000_0001);
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    `CHK(q[0], 1'b0)
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    `CHK(pslverr, 1'b0)
    $display("test write and unmapped done");
    print_verdict();
  end
endmodule : erase_error_descriptor_decode_tb
